// ==== hw/dsr_pin_sync.sv ====
// dsr_pin_sync: three-stage synchroniser for asynchronous pin levels.
// assumes: inputs are slow levels; a change is taken once stages two and
// three agree.
`timescale 1ns/10ps

module dsr_pin_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             i_clock,
   input  wire logic             i_rst_n,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_level
);

   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;
   logic [WIDTH-1:0] level_r;

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         meta_r <= '0;
         s2_r   <= '0;
         s3_r   <= '0;
      end else begin
         meta_r <= i_async;
         s2_r   <= meta_r;
         s3_r   <= s2_r;
      end
   end

   // per bit: accept only when the two settled stages agree
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         level_r <= '0;
      end else begin
         for (int i = 0; i < WIDTH; i++) begin
            if (s2_r[i] == s3_r[i]) begin
               level_r[i] <= s3_r[i];
            end
         end
      end
   end

   assign o_level = level_r;

endmodule

// ==== hw/dsr_pkg.sv ====
// dsr_pkg: offsets, field positions, reset values and state codes for the
// device status readout registers.
// assumes: consumers reference every item as dsr_pkg::name.

package dsr_pkg;

   // ----------------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------------
   localparam int          ADDR_W          = 7;
   localparam int          DATA_W          = 24;
   localparam logic [6:0]  ADDR_STATE      = 7'h25;
   localparam logic [6:0]  ADDR_WAKE       = 7'h26;
   localparam logic [6:0]  ADDR_SUPPLY     = 7'h27;
   localparam logic [23:0] REG_RESET       = 24'h000000;

   // ----------------------------------------------------------------------
   // state_and_cause_status fields
   // ----------------------------------------------------------------------
   localparam int          ST_CODE_LSB     = 10;
   localparam int          ST_DS_CAUSE_LSB = 8;
   localparam int          ST_FORCED_BIT   = 7;
   localparam int          ST_PRIOR_BIT    = 6;
   localparam int          ST_R2_CAUSE_LSB = 4;

   // ----------------------------------------------------------------------
   // wake_and_pin_status fields
   // ----------------------------------------------------------------------
   localparam int          WK_LP_BIT       = 22;
   localparam int          WK_TIED_BIT     = 21;
   localparam int          WK_DBG_BIT      = 20;
   localparam int          WK_FAULT_BIT    = 14;
   localparam int          WK_IGN_LVL_BIT  = 13;
   localparam int          WK_WU_LVL_BIT   = 12;
   localparam int          WK_IGN_WK_BIT   = 11;
   localparam int          WK_WU_WK_BIT    = 10;
   localparam int          WK_TMR_WK_BIT   = 8;
   localparam int          WK_IRQ_LVL_BIT  = 7;
   localparam int          WK_MCU_RESET_OUTPUT_BIT     = 6;
   localparam int          WK_IRQ_SENT_BIT = 5;
   localparam int          WK_FS_BIT       = 4;

   // ----------------------------------------------------------------------
   // supply_watchdog_counter_status fields
   // ----------------------------------------------------------------------
   localparam int          SP_POR_BIT      = 22;
   localparam int          SP_LR1_PG_BIT   = 21;
   localparam int          SP_TRK_EN_BIT   = 20;
   localparam int          SP_TRK_PG_BIT   = 19;
   localparam int          SP_FCM_EN_BIT   = 18;
   localparam int          SP_WD_EN_BIT    = 17;
   localparam int          SP_WD_PH_LSB    = 15;
   localparam int          SP_WD_FAIL_LSB  = 11;
   localparam int          SP_TSD_LSB      = 9;
   localparam int          SP_PUR_HI_BIT   = 8;
   localparam int          SP_PUR_LO_BIT   = 7;
   localparam logic [3:0]  WD_FAIL_MAX     = 4'hf;
   localparam logic [3:0]  WD_FAIL_RESET   = 4'h0;
   localparam logic [1:0]  PUR_RESET       = 2'h0;
   localparam logic [1:0]  PUR_MAX         = 2'h3;

   // ----------------------------------------------------------------------
   // main state machine codes
   // ----------------------------------------------------------------------
   localparam logic [5:0]  CODE_START_UP   = 6'h00;
   localparam logic [5:0]  CODE_ACTIVE_FP  = 6'h01;
   localparam logic [5:0]  CODE_ACTIVE_LP  = 6'h02;
   localparam logic [5:0]  CODE_DEEP_SLEEP = 6'h0d;
   localparam logic [5:0]  CODE_RECOVERY1  = 6'h18;
   localparam logic [5:0]  CODE_RECOVERY2  = 6'h19;

   // ----------------------------------------------------------------------
   // pin synchroniser
   // ----------------------------------------------------------------------
   localparam int          PIN_COUNT       = 7;

endpackage

// ==== hw/dsr_status_regs.sv ====
// dsr_status_regs: three read-only / read-to-clear status registers.
// assumes: upstream framing gives read strobe, address, clear; adds crc.
// How it works
// - live six-bit state code in 15:10
// - state codes fixed per package constants
// - 9:8 deep-sleep power-down cause, 01/1x
// - 5:4 recovery-two power-cycle cause, 01/1x
// - bit 7 forced sleep after retries
// - bit 6 latches state before recovery two
// - bit 22 low-power entry, irq unless masked
// - bit 21 debug tied flag; irq, window unless masked
// - bit 20 live debug pin level
// - bit 14 live fault pin level
// - 13:12 live only when wake-enabled
// - wake source flags 11, 10, 8 sticky
// - bits 7, 6, 4 echo output pins
// - bit 5 set on irq request rise
// - bit 22 supply por flag sticky
// - bit 21 linreg1 power-good sticky
// - bit 20 live tracker enable status
// - bit 19 tracker power-good after enable
// - bit 18 live fault monitor enable echo
// - bit 17 live watchdog enable echo
// - 16:15 watchdog window phase
// - read-only counters in 14:9, read-to-clear retry counter in 8:7
// - fail counter 0..15, saturating, no command clear
`timescale 1ns/10ps

module dsr_status_regs (
   input  wire logic        i_clock,
   input  wire logic        i_rst_n,
   input  wire logic        i_rd_en,
   input  wire logic        i_rd_clear,
   input  wire logic [6:0]  i_rd_addr,
   output logic      [23:0] o_rd_data,
   output logic             o_rd_valid,
   output logic             o_rd_unmapped,
   input  wire logic [5:0]  i_fsm_state_code,
   input  wire logic        i_pd_cmd_from_active,
   input  wire logic        i_pd_cmd_from_rec1,
   input  wire logic        i_pc_cmd_from_active,
   input  wire logic        i_pc_cmd_from_rec1,
   input  wire logic        i_forced_sleep_event,
   input  wire logic        i_low_power_entered,
   input  wire logic        i_low_power_irq_mask,
   input  wire logic        i_debug_tied_event,
   input  wire logic        i_debug_tied_irq_mask,
   output logic             o_irq_request,
   output logic             o_wd_long_window_start,
   input  wire logic        i_debug_input_pin,
   input  wire logic        i_fault_input_pin,
   input  wire logic        i_ignition_input,
   input  wire logic        i_wake_input_pin,
   input  wire logic        i_irq_pin,
   input  wire logic        i_mcu_reset_output,
   input  wire logic        i_failsafe_output,
   input  wire logic        i_ignition_wake_en,
   input  wire logic        i_wake_pin_wake_en,
   input  wire logic        i_ignition_wake_event,
   input  wire logic        i_pin_wake_event,
   input  wire logic        i_timer_wake_event,
   input  wire logic        i_irq_request_int,
   input  wire logic        i_supply_por_event,
   input  wire logic        i_linreg1_power_good,
   input  wire logic        i_tracker_enabled,
   input  wire logic        i_tracker_power_good,
   input  wire logic        i_fault_monitor_enable,
   input  wire logic        i_watchdog_enable,
   input  wire logic [1:0]  i_watchdog_window_phase,
   input  wire logic        i_wd_trigger_fault,
   input  wire logic        i_wd_valid_long_window,
   input  wire logic [1:0]  i_thermal_retry_counter,
   input  wire logic        i_powerup_retry_event
);

   // ----------------------------------------------------------------------
   // access decode
   // ----------------------------------------------------------------------
   logic        hit_state;
   logic        hit_wake;
   logic        hit_supply;
   logic        clr_state;
   logic        clr_wake;
   logic        clr_supply;

   assign hit_state  = (i_rd_addr == dsr_pkg::ADDR_STATE);
   assign hit_wake   = (i_rd_addr == dsr_pkg::ADDR_WAKE);
   assign hit_supply = (i_rd_addr == dsr_pkg::ADDR_SUPPLY);
   assign clr_state  = i_rd_en & i_rd_clear & hit_state;
   assign clr_wake   = i_rd_en & i_rd_clear & hit_wake;
   assign clr_supply = i_rd_en & i_rd_clear & hit_supply;

   // ----------------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------------
   logic [dsr_pkg::PIN_COUNT-1:0] pin_level;

   // pin_level: 0 debug, 1 fault, 2 ignition, 3 wake, 4 irq, 5 reset, 6 failsafe
   dsr_pin_sync #(.WIDTH(dsr_pkg::PIN_COUNT)) u_pin_sync (
      .i_clock (i_clock),
      .i_rst_n (i_rst_n),
      .i_async ({i_failsafe_output, i_mcu_reset_output, i_irq_pin, i_wake_input_pin,
                 i_ignition_input, i_fault_input_pin, i_debug_input_pin}),
      .o_level (pin_level)
   );

   // ----------------------------------------------------------------------
   // state_and_cause_status
   // ----------------------------------------------------------------------
   logic [5:0]  prev_code_r;
   logic        rec2_entry;
   logic        prior_state_before_recovery2_r;
   logic [4:0]  st_flags;

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         prev_code_r <= dsr_pkg::CODE_START_UP;
      end else begin
         prev_code_r <= i_fsm_state_code;
      end
   end

   assign rec2_entry = (i_fsm_state_code == dsr_pkg::CODE_RECOVERY2) &&
                       (prev_code_r != dsr_pkg::CODE_RECOVERY2);

   // deep-sleep cause, forced sleep, recovery-two cause
   dsr_sticky #(.WIDTH(5)) u_state_flags (
      .i_clock (i_clock),
      .i_rst_n (i_rst_n),
      .i_set   ({i_pd_cmd_from_rec1, i_pd_cmd_from_active,
                 i_forced_sleep_event,
                 i_pc_cmd_from_rec1, i_pc_cmd_from_active}),
      .i_clear (clr_state),
      .o_flag  (st_flags)
   );

   // prior state captured at recovery-two entry; entry beats a clear
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         prior_state_before_recovery2_r <= 1'b0;
      end else if (rec2_entry) begin
         prior_state_before_recovery2_r <= (prev_code_r == dsr_pkg::CODE_RECOVERY1);
      end else if (clr_state) begin
         prior_state_before_recovery2_r <= 1'b0;
      end
   end

   logic [23:0] state_word;
   always_comb begin
      state_word = dsr_pkg::REG_RESET;
      state_word[dsr_pkg::ST_CODE_LSB +: 6]   = i_fsm_state_code;
      state_word[dsr_pkg::ST_DS_CAUSE_LSB +: 2] = st_flags[4:3];
      state_word[dsr_pkg::ST_FORCED_BIT]        = st_flags[2];
      state_word[dsr_pkg::ST_PRIOR_BIT]         = prior_state_before_recovery2_r;
      state_word[dsr_pkg::ST_R2_CAUSE_LSB +: 2] = st_flags[1:0];
   end

   // ----------------------------------------------------------------------
   // wake_and_pin_status
   // ----------------------------------------------------------------------
   logic        lp_set;
   logic        tied_set;
   logic        irq_req_d_r;
   logic        irq_sent_set;
   logic [5:0]  wk_flags;
   logic        ignition_level_r;
   logic        wake_pin_level_r;

   assign lp_set       = i_low_power_entered & ~i_low_power_irq_mask;
   assign tied_set     = i_debug_tied_event;
   assign irq_sent_set = i_irq_request_int & ~irq_req_d_r;

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         irq_req_d_r <= 1'b0;
      end else begin
         irq_req_d_r <= i_irq_request_int;
      end
   end

   dsr_sticky #(.WIDTH(6)) u_wake_flags (
      .i_clock (i_clock),
      .i_rst_n (i_rst_n),
      .i_set   ({lp_set, tied_set, irq_sent_set, i_ignition_wake_event, i_pin_wake_event,
                 i_timer_wake_event}),
      .i_clear (clr_wake),
      .o_flag  (wk_flags)
   );

   // pin levels follow only while the pin is a wake input
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         ignition_level_r <= 1'b0;
         wake_pin_level_r <= 1'b0;
      end else begin
         if (i_ignition_wake_en) begin
            ignition_level_r <= pin_level[2];
         end
         if (i_wake_pin_wake_en) begin
            wake_pin_level_r <= pin_level[3];
         end
      end
   end

   // interrupt pulse and long open window start
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_irq_request          <= 1'b0;
         o_wd_long_window_start <= 1'b0;
      end else begin
         o_irq_request          <= lp_set |
                                   (i_debug_tied_event & ~i_debug_tied_irq_mask);
         o_wd_long_window_start <= i_debug_tied_event & ~i_debug_tied_irq_mask;
      end
   end

   logic [23:0] wake_word;
   always_comb begin
      wake_word = dsr_pkg::REG_RESET;
      wake_word[dsr_pkg::WK_LP_BIT]       = wk_flags[5];
      wake_word[dsr_pkg::WK_TIED_BIT]     = wk_flags[4];
      wake_word[dsr_pkg::WK_DBG_BIT]      = pin_level[0];
      wake_word[dsr_pkg::WK_FAULT_BIT]    = pin_level[1];
      wake_word[dsr_pkg::WK_IGN_LVL_BIT]  = ignition_level_r;
      wake_word[dsr_pkg::WK_WU_LVL_BIT]   = wake_pin_level_r;
      wake_word[dsr_pkg::WK_IGN_WK_BIT]   = wk_flags[2];
      wake_word[dsr_pkg::WK_WU_WK_BIT]    = wk_flags[1];
      wake_word[dsr_pkg::WK_TMR_WK_BIT]   = wk_flags[0];
      wake_word[dsr_pkg::WK_IRQ_LVL_BIT]  = pin_level[4];
      wake_word[dsr_pkg::WK_MCU_RESET_OUTPUT_BIT]     = pin_level[5];
      wake_word[dsr_pkg::WK_IRQ_SENT_BIT] = wk_flags[3];
      wake_word[dsr_pkg::WK_FS_BIT]       = pin_level[6];
   end

   // ----------------------------------------------------------------------
   // supply_watchdog_counter_status
   // ----------------------------------------------------------------------
   logic [1:0]  sp_flags;
   logic        tracker_power_good_r;
   logic [3:0]  watchdog_fail_counter_r;
   logic [1:0]  powerup_retry_counter_r;

   dsr_sticky #(.WIDTH(2)) u_supply_flags (
      .i_clock (i_clock),
      .i_rst_n (i_rst_n),
      .i_set   ({i_supply_por_event, i_linreg1_power_good}),
      .i_clear (clr_supply),
      .o_flag  (sp_flags)
   );

   // power-good seen since the tracker was last enabled
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         tracker_power_good_r <= 1'b0;
      end else if (!i_tracker_enabled) begin
         tracker_power_good_r <= 1'b0;
      end else if (i_tracker_power_good) begin
         tracker_power_good_r <= 1'b1;
      end
   end

   // consecutive trigger faults, saturating; no command clear
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         watchdog_fail_counter_r <= dsr_pkg::WD_FAIL_RESET;
      end else if (i_wd_valid_long_window ||
                   i_fsm_state_code == dsr_pkg::CODE_DEEP_SLEEP) begin
         watchdog_fail_counter_r <= dsr_pkg::WD_FAIL_RESET;
      end else if (i_wd_trigger_fault &&
                   watchdog_fail_counter_r != dsr_pkg::WD_FAIL_MAX) begin
         watchdog_fail_counter_r <= watchdog_fail_counter_r + 4'h1;
      end
   end

   // retry counter cleared by read-and-clear; a count beats the clear
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         powerup_retry_counter_r <= dsr_pkg::PUR_RESET;
      end else if (i_powerup_retry_event) begin
         if (clr_supply) begin
            powerup_retry_counter_r <= 2'h1;
         end else if (powerup_retry_counter_r != dsr_pkg::PUR_MAX) begin
            powerup_retry_counter_r <= powerup_retry_counter_r + 2'h1;
         end
      end else if (clr_supply) begin
         powerup_retry_counter_r <= dsr_pkg::PUR_RESET;
      end
   end

   logic [23:0] supply_word;
   always_comb begin
      supply_word = dsr_pkg::REG_RESET;
      supply_word[dsr_pkg::SP_POR_BIT]         = sp_flags[1];
      supply_word[dsr_pkg::SP_LR1_PG_BIT]      = sp_flags[0];
      supply_word[dsr_pkg::SP_TRK_EN_BIT]      = i_tracker_enabled;
      supply_word[dsr_pkg::SP_TRK_PG_BIT]      = tracker_power_good_r;
      supply_word[dsr_pkg::SP_FCM_EN_BIT]      = i_fault_monitor_enable;
      supply_word[dsr_pkg::SP_WD_EN_BIT]       = i_watchdog_enable;
      supply_word[dsr_pkg::SP_WD_PH_LSB +: 2]  = i_watchdog_window_phase;
      supply_word[dsr_pkg::SP_WD_FAIL_LSB +: 4] = watchdog_fail_counter_r;
      supply_word[dsr_pkg::SP_TSD_LSB +: 2]    = i_thermal_retry_counter;
      supply_word[dsr_pkg::SP_PUR_HI_BIT]      = powerup_retry_counter_r[1];
      supply_word[dsr_pkg::SP_PUR_LO_BIT]      = powerup_retry_counter_r[0];
   end

   // ----------------------------------------------------------------------
   // read data return
   // ----------------------------------------------------------------------
   logic [23:0] rd_mux;
   always_comb begin
      rd_mux = dsr_pkg::REG_RESET;
      if (hit_state) begin
         rd_mux = state_word;
      end else if (hit_wake) begin
         rd_mux = wake_word;
      end else if (hit_supply) begin
         rd_mux = supply_word;
      end
   end

   // data is captured before the clear takes effect
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_rd_data     <= dsr_pkg::REG_RESET;
         o_rd_valid    <= 1'b0;
         o_rd_unmapped <= 1'b0;
      end else begin
         o_rd_valid    <= i_rd_en;
         o_rd_unmapped <= i_rd_en & ~(hit_state | hit_wake | hit_supply);
         if (i_rd_en) begin
            o_rd_data <= rd_mux;
         end
      end
   end

endmodule

// ==== hw/dsr_sticky.sv ====
// dsr_sticky: vector of event flags, set by hardware, cleared by command.
// assumes: set and clear are one-cycle pulses on i_clock.
`timescale 1ns/10ps

module dsr_sticky #(
   parameter int WIDTH = 1
) (
   input  wire logic             i_clock,
   input  wire logic             i_rst_n,
   input  wire logic [WIDTH-1:0] i_set,
   input  wire logic             i_clear,
   output logic      [WIDTH-1:0] o_flag
);

   logic [WIDTH-1:0] flag_r;
   logic [WIDTH-1:0] flag_nxt;

   // set beats a clear in the same cycle
   always_comb begin
      flag_nxt = (i_clear ? '0 : flag_r) | i_set;
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         flag_r <= '0;
      end else begin
         flag_r <= flag_nxt;
      end
   end

   assign o_flag = flag_r;

endmodule

// ==== sim/dsr_host_model.sv ====
// dsr_host_model: host issuing single-cycle read strobes
// assumes: answer one cycle after the strobe edge
`timescale 1ns/10ps
module dsr_host_model (
   input  wire logic        i_clock,
   input  wire logic        i_rd_valid,
   input  wire logic        i_rd_unmapped,
   input  wire logic [23:0] i_rd_data,
   output logic             o_rd_en,
   output logic             o_rd_clear,
   output logic      [6:0]  o_rd_addr
);
   initial begin
      o_rd_en = 1'b0;
      o_rd_clear = 1'b0;
      o_rd_addr = 7'h00;
   end
   task automatic rd(input logic [6:0] a, input logic c, output logic [23:0] d,
                     output logic u);
      @(negedge i_clock);
      o_rd_en = 1'b1;
      o_rd_clear = c;
      o_rd_addr = a;
      @(negedge i_clock);
      d = i_rd_valid ? i_rd_data : 24'hxxxxxx;
      u = i_rd_unmapped;
      o_rd_en = 1'b0;
      o_rd_clear = 1'b0;
      // released address shows garbage
      o_rd_addr = ~a;
   endtask
endmodule

// ==== sim/dsr_status_regs_assertions.sv ====
// dsr_status_regs_chk: port timing checks for the status register bank
// assumes: one clock, sync active-low reset, bound to dsr_status_regs
`timescale 1ns/10ps
module dsr_status_regs_chk (
   input wire logic        i_clock,
   input wire logic        i_rst_n,
   input wire logic        i_rd_en,
   input wire logic [6:0]  i_rd_addr,
   input wire logic [5:0]  i_fsm_state_code,
   input wire logic        i_low_power_entered,
   input wire logic        i_low_power_irq_mask,
   input wire logic        i_debug_tied_event,
   input wire logic        i_debug_tied_irq_mask,
   input wire logic [23:0] o_rd_data,
   input wire logic        o_rd_valid,
   input wire logic        o_rd_unmapped,
   input wire logic        o_irq_request,
   input wire logic        o_wd_long_window_start
);
   wire logic lp_go = i_low_power_entered && !i_low_power_irq_mask;
   wire logic tie_go = i_debug_tied_event && !i_debug_tied_irq_mask;
   wire logic irq_go = lp_go || tie_go;
   wire logic hit = i_rd_addr >= 7'h25 && i_rd_addr <= 7'h27;
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   sequence s_read; i_rd_en ##1 o_rd_valid; endsequence
   sequence s_win; o_wd_long_window_start ##1 !o_wd_long_window_start; endsequence
   property p_answer; i_rd_en |-> s_read; endproperty
   property p_quiet; !i_rd_en |=> !o_rd_valid && $stable(o_rd_data); endproperty
   property p_state; i_rd_en && i_rd_addr == 7'h25 |=> o_rd_data[15:10] == $past(i_fsm_state_code); endproperty
   property p_unmapped; i_rd_en && !hit |=> o_rd_unmapped && o_rd_data == 24'h0; endproperty
   property p_mapped; i_rd_en && hit |=> !o_rd_unmapped; endproperty
   property p_spare; o_rd_valid |-> o_rd_data[3:0] == 4'h0 && !o_rd_data[23]; endproperty
   property p_irq; lp_go |=> o_irq_request; endproperty
   property p_irq_src; o_irq_request |-> $past(irq_go); endproperty
   property p_win; tie_go |=> s_win; endproperty
   property p_win_src; o_wd_long_window_start |-> $past(tie_go); endproperty
   a_answer: assert property (p_answer) else $error("read not answered");
   a_quiet: assert property (p_quiet) else $error("data moved without read");
   a_state: assert property (p_state) else $error("state code wrong");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read wrong");
   a_mapped: assert property (p_mapped) else $error("mapped read flagged");
   a_spare: assert property (p_spare) else $error("spare bits set");
   a_irq: assert property (p_irq) else $error("no irq on low power");
   a_irq_src: assert property (p_irq_src) else $error("irq without cause");
   a_win: assert property (p_win) else $error("no long window start");
   a_win_src: assert property (p_win_src) else $error("window start without cause");
endmodule
bind dsr_status_regs dsr_status_regs_chk u_chk (.i_clock(i_clock), .i_rst_n(i_rst_n),
   .i_rd_en(i_rd_en), .i_rd_addr(i_rd_addr), .i_fsm_state_code(i_fsm_state_code),
   .i_low_power_entered(i_low_power_entered), .i_low_power_irq_mask(i_low_power_irq_mask),
   .i_debug_tied_event(i_debug_tied_event), .i_debug_tied_irq_mask(i_debug_tied_irq_mask),
   .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .o_rd_unmapped(o_rd_unmapped),
   .o_irq_request(o_irq_request), .o_wd_long_window_start(o_wd_long_window_start));

// ==== sim/dsr_status_regs_tb.sv ====
// dsr_status_regs_tb: directed and random reads against a reference model
// assumes: package, design, host model and checker compiled first
`timescale 1ns/10ps
module dsr_status_regs_tb;
   logic        i_clock, i_rst_n, rd_en, rd_clr, valid, unm;
   logic [6:0]  rd_addr;
   logic [23:0] rd_data;
   logic [5:0]  code;
   logic [14:0] ev_v;
   logic [19:0] lv;
   int          m[3], fail, pur, ign_l, wu_l, trk, err_count, compares;
   int          bpos[15] = '{8, 9, 4, 5, 7, 22, 21, 11, 10, 8, 22, 0, 0, 0, 5};
   int          breg[15] = '{0, 0, 0, 0, 0, 1, 1, 1, 1, 1, 2, 0, 0, 0, 1};
   int          clrm[3] = '{32'h3f0, 32'h600d20, 32'h600000};
   dsr_status_regs uut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_rd_en(rd_en),
      .i_rd_clear(rd_clr), .i_rd_addr(rd_addr), .o_rd_data(rd_data), .o_rd_valid(valid),
      .o_rd_unmapped(unm), .i_fsm_state_code(code), .i_pd_cmd_from_active(ev_v[0]),
      .i_pd_cmd_from_rec1(ev_v[1]), .i_pc_cmd_from_active(ev_v[2]),
      .i_pc_cmd_from_rec1(ev_v[3]), .i_forced_sleep_event(ev_v[4]),
      .i_low_power_entered(ev_v[5]), .i_low_power_irq_mask(lv[9]),
      .i_debug_tied_event(ev_v[6]), .i_debug_tied_irq_mask(lv[19]), .o_irq_request(),
      .o_wd_long_window_start(), .i_debug_input_pin(lv[0]), .i_fault_input_pin(lv[1]),
      .i_ignition_input(lv[2]), .i_wake_input_pin(lv[3]), .i_irq_pin(lv[4]),
      .i_mcu_reset_output(lv[5]), .i_failsafe_output(lv[6]), .i_ignition_wake_en(lv[7]),
      .i_wake_pin_wake_en(lv[8]), .i_ignition_wake_event(ev_v[7]),
      .i_pin_wake_event(ev_v[8]), .i_timer_wake_event(ev_v[9]),
      .i_irq_request_int(ev_v[14]), .i_supply_por_event(ev_v[10]),
      .i_linreg1_power_good(lv[10]), .i_tracker_enabled(lv[11]),
      .i_tracker_power_good(lv[12]), .i_fault_monitor_enable(lv[14]),
      .i_watchdog_enable(lv[13]), .i_watchdog_window_phase(lv[16:15]),
      .i_wd_trigger_fault(ev_v[11]), .i_wd_valid_long_window(ev_v[12]),
      .i_thermal_retry_counter(lv[18:17]), .i_powerup_retry_event(ev_v[13]));
   dsr_host_model host (.i_clock(i_clock), .i_rd_valid(valid), .i_rd_unmapped(unm),
      .i_rd_data(rd_data), .o_rd_en(rd_en), .o_rd_clear(rd_clr), .o_rd_addr(rd_addr));
   always #2 i_clock = ~i_clock;
   function automatic int expv(logic [6:0] a);
      case (a)
         7'h25: return m[0] | code << 10;
         7'h26: return m[1] | lv[0] << 20 | lv[1] << 14 | ign_l << 13 | wu_l << 12
                   | lv[4] << 7 | lv[5] << 6 | lv[6] << 4;
         7'h27: return m[2] | lv[11] << 20 | trk << 19 | lv[14:13] << 17 | lv[16:15] << 15
                   | fail << 11 | lv[18:17] << 9 | pur[1] << 8 | pur[0] << 7;
         default: return 0;
      endcase
   endfunction
   task automatic setlv(input logic [5:0] c);
      @(negedge i_clock);
      lv = 20'($urandom);
      if (lv[7]) ign_l = lv[2];
      if (lv[8]) wu_l = lv[3];
      trk = lv[11] ? trk | lv[12] : 0;
      if (lv[10]) m[2] |= 32'h200000;
      if (c == 6'h19 && code != 6'h19) m[0] = m[0] & ~32'h40 | int'(code == 6'h18) << 6;
      if (c == 6'h0d) fail = 0;
      code = c;
      repeat (8) @(negedge i_clock);
   endtask
   task automatic ev(input int n);
      @(negedge i_clock);
      ev_v = 15'(1 << n);
      @(negedge i_clock);
      ev_v = '0;
      if ((n < 11 || n == 14) && !(n == 5 && lv[9])) m[breg[n]] |= 1 << bpos[n];
      if (n == 11 && code != 6'h0d && fail < 15) fail++;
      if (n == 12) fail = 0;
      if (n == 13 && pur < 3) pur++;
   endtask
   task automatic chk(input logic [6:0] a, input logic c);
      logic [23:0] d;
      logic        u, eu;
      int          e;
      e = expv(a);
      eu = a < 7'h25 || a > 7'h27;
      host.rd(a, c, d, u);
      compares++;
      if ({u, d} !== {eu, e[23:0]}) begin
         err_count++;
         $display("[ERR] reg %h exp %h seen %h", a, {eu, e[23:0]}, {u, d});
      end
      if (c && !eu) m[a - 7'h25] &= ~clrm[a - 7'h25];
      if (c && a == 7'h27) pur = 0;
      if (lv[10]) m[2] |= 32'h200000;
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      #40000;
      err_count++;
      $display("[ERR] run exp finished seen hang");
      summarize();
   end
   initial begin
      {i_clock, i_rst_n, ev_v, lv, code} = '0;
      void'($urandom(32'h7a80));
      repeat (4) @(negedge i_clock);
      i_rst_n = 1'b1;
      repeat (6) @(negedge i_clock);
      for (int a = 'h24; a < 'h29; a++) chk(7'(a), 1'b0);
      $display("test reset_values done");
      setlv(6'h18);
      setlv(6'h19);
      chk(7'h25, 1'b1);
      setlv(6'h01);
      setlv(6'h19);
      chk(7'h25, 1'b1);
      $display("test recovery_entry done");
      repeat (17) ev(11);
      chk(7'h27, 1'b0);
      ev(12);
      repeat (2) ev(11);
      setlv(6'h0d);
      chk(7'h27, 1'b0);
      setlv(6'h01);
      repeat (4) ev(13);
      chk(7'h27, 1'b1);
      chk(7'h27, 1'b0);
      $display("test counters done");
      for (int n = 0; n < 15; n++) ev(n);
      for (int a = 'h25; a < 'h28; a++) chk(7'(a), 1'b1);
      repeat (40) begin
         setlv(6'($urandom_range(0, 37)));
         repeat (3) ev($urandom_range(0, 14));
         for (int a = 'h25; a < 'h28; a++) chk(7'(a), 1'($urandom_range(0, 1)));
      end
      $display("test random done");
      summarize();
   end
endmodule
